// ==== core/elpc_top.v ====
// echo line processing chain: timing, beamformer setup, demodulation
// assumes: one CLK domain, samples arrive on a slow sampled link clock
`timescale 1ns/1ps
`default_nettype none
`include "elpc_map.vh"

////////////////////////////////////////////////////////////////////////
// small fifo, depth a power of two
module elpc_fifo #(
  parameter W = 33,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk, // core clock
  input wire rst, // async reset
  input wire [W-1:0] in_data, // write word
  input wire in_valid, // write request
  output wire in_ready, // room left
  output wire [W-1:0] out_data, // head word
  output wire out_valid, // head present
  input wire out_ready // head taken
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // storage has no reset, only pointers and fill level do
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  // pointers and fill level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
module elpc_top #(
  parameter PW = 6,
  parameter SW = 2,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire CLK, // 125 MHz core clock
  input wire RESET, // async, active high
  input wire [5:0] AVS_ADDRESS, // byte address
  input wire AVS_READ, // read request
  input wire AVS_WRITE, // write request
  input wire [31:0] AVS_WRITEDATA, // write data
  output reg [31:0] AVS_READDATA, // read data
  output reg AVS_WAITREQUEST, // stall
  output reg BF_CLK_EN, // enables 200 MHz beamformer clock
  output reg SHOT_TRIG, // one-cycle shot start
  output reg CFG_STB, // config word valid
  output reg [1:0] CFG_ADDR, // config word index
  output reg [31:0] CFG_DATA, // config word
  input wire SMP_CLK, // sample link clock
  input wire [15:0] SMP_DATA, // beamformed sample
  output reg [31:0] SD_WR_DATA, // word to SDRAM fifo
  output reg SD_WR_VALID, // word valid
  input wire SD_WR_READY, // SDRAM fifo accepts
  output reg SD_DMA_SEL, // DMA controller index
  output reg [1:0] SD_CHAN // signal processor channel
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CFG = 2'h1;
  localparam ST_TRIG = 2'h2;

  reg [6:0] ctrl_q;
  reg ovr_q;
  reg [23:0] prf_q;
  reg [31:0] txset_q;
  reg [31:0] line_q;
  reg [15:0] rxf_q;
  reg [15:0] gain_q;
  reg [11:0] shape_q;
  wire req;
  wire wr_do;
  wire [1:0] mode;
  wire dop;
  wire pair;
  wire go;
  reg coll_q;
  reg dr_busy_q;
  wire f_in_ready;
  assign req = AVS_READ | AVS_WRITE;
  assign wr_do = AVS_WRITE & ~AVS_WAITREQUEST;
  assign mode = ctrl_q[`ELPC_CTRL_MODE];
  assign dop = (mode == `ELPC_MODE_D);
  assign pair = ctrl_q[`ELPC_CTRL_PINV] | ctrl_q[`ELPC_CTRL_FCOMP];

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state, read data staged a cycle early
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
      ctrl_q <= 7'h00;
      prf_q <= `ELPC_RST_PRF;
      txset_q <= `ELPC_RST_TXSET;
      line_q <= 32'h0000_0000;
      rxf_q <= `ELPC_RST_RXF;
      gain_q <= `ELPC_RST_GAIN;
      shape_q <= `ELPC_RST_SHAPE;
    end else begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
      if (req & AVS_WAITREQUEST) begin
        case (AVS_ADDRESS)
          `ELPC_OFF_CTRL: AVS_READDATA <= {25'h0, ctrl_q};
          `ELPC_OFF_STATUS: AVS_READDATA <= {28'h0, ~f_in_ready, dr_busy_q, ovr_q, coll_q};
          `ELPC_OFF_PRF: AVS_READDATA <= {8'h00, prf_q};
          `ELPC_OFF_TXSET: AVS_READDATA <= txset_q;
          `ELPC_OFF_LINE: AVS_READDATA <= line_q;
          `ELPC_OFF_RXF: AVS_READDATA <= {16'h0000, rxf_q};
          `ELPC_OFF_GAIN: AVS_READDATA <= {16'h0000, gain_q};
          `ELPC_OFF_SHAPE: AVS_READDATA <= {20'h0_0000, shape_q};
          default: AVS_READDATA <= 32'h0000_0000;
        endcase
      end
      if (wr_do) begin
        case (AVS_ADDRESS)
          `ELPC_OFF_CTRL: ctrl_q <= AVS_WRITEDATA[6:0];
          `ELPC_OFF_PRF: prf_q <= AVS_WRITEDATA[23:0];
          `ELPC_OFF_TXSET: txset_q <= AVS_WRITEDATA;
          `ELPC_OFF_LINE: line_q <= AVS_WRITEDATA;
          `ELPC_OFF_RXF: rxf_q <= AVS_WRITEDATA[15:0];
          `ELPC_OFF_GAIN: gain_q <= AVS_WRITEDATA[15:0];
          `ELPC_OFF_SHAPE: shape_q <= AVS_WRITEDATA[11:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse repetition: load beamformer setup, then fire the shot
  reg [1:0] st_q;
  reg [23:0] prf_cnt_q;
  reg [1:0] cfg_idx_q;
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_q <= ST_IDLE;
      prf_cnt_q <= 24'h00_0000;
      cfg_idx_q <= 2'h0;
      BF_CLK_EN <= 1'b0;
      SHOT_TRIG <= 1'b0;
      CFG_STB <= 1'b0;
      CFG_ADDR <= 2'h0;
      CFG_DATA <= 32'h0000_0000;
    end else begin
      BF_CLK_EN <= ctrl_q[`ELPC_CTRL_EN];
      SHOT_TRIG <= 1'b0;
      CFG_STB <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (!ctrl_q[`ELPC_CTRL_EN]) begin
            prf_cnt_q <= 24'h00_0000;
          end else if (prf_cnt_q >= prf_q) begin
            prf_cnt_q <= 24'h00_0000;
            cfg_idx_q <= 2'h0;
            st_q <= ST_CFG;
          end else begin
            prf_cnt_q <= prf_cnt_q + 24'h00_0001;
          end
        end
        // setup words go out every shot, so a change lands on the next one
        ST_CFG: begin
          CFG_STB <= 1'b1;
          CFG_ADDR <= cfg_idx_q;
          case (cfg_idx_q)
            2'h0: CFG_DATA <= txset_q;
            2'h1: CFG_DATA <= line_q;
            default: CFG_DATA <= {26'h0, ctrl_q[5:0]};
          endcase
          if (cfg_idx_q == `ELPC_CFG_WORDS - 2'h1) begin
            st_q <= ST_TRIG;
          end
          cfg_idx_q <= cfg_idx_q + 2'h1;
        end
        ST_TRIG: begin
          SHOT_TRIG <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link capture: two flops, then rising edge of the link clock
  reg [2:0] lclk_q;
  reg [15:0] ld1_q;
  reg [15:0] ld2_q;
  wire smp_stb;
  assign smp_stb = lclk_q[1] & ~lclk_q[2];
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      lclk_q <= 3'h0;
      ld1_q <= 16'h0000;
      ld2_q <= 16'h0000;
    end else begin
      lclk_q <= {lclk_q[1:0], SMP_CLK};
      ld1_q <= SMP_DATA;
      ld2_q <= ld1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // deinterleave: two banks, written pixel-major, read shot-major
  reg signed [15:0] dmem [0:(1<<(SW+PW+1))-1];
  reg wbank_q;
  reg [SW-1:0] ws_q;
  reg [PW-1:0] wp_q;
  reg rbank_q;
  reg [SW-1:0] rs_q;
  reg [PW-1:0] rp_q;
  wire [SW-1:0] nshot;
  wire [PW-1:0] npix;
  wire coll_end;
  wire dr_end;
  assign nshot = line_q[24+SW-1:24];
  assign npix = shape_q[PW-1:0];
  assign coll_end = smp_stb & coll_q & (ws_q == nshot) & (wp_q == npix);
  assign dr_end = go & dr_busy_q & (rs_q == nshot) & (rp_q == npix);
  always @(posedge CLK) begin
    if (smp_stb & coll_q) begin
      dmem[{wbank_q, ws_q, wp_q}] <= ld2_q;
    end
  end
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      coll_q <= 1'b0;
      wbank_q <= 1'b0;
      ws_q <= {SW{1'b0}};
      wp_q <= {PW{1'b0}};
      dr_busy_q <= 1'b0;
      rbank_q <= 1'b0;
      rs_q <= {SW{1'b0}};
      rp_q <= {PW{1'b0}};
      ovr_q <= 1'b0;
    end else begin
      if (SHOT_TRIG) begin
        coll_q <= 1'b1;
        ws_q <= {SW{1'b0}};
        wp_q <= {PW{1'b0}};
      end else if (coll_end) begin
        coll_q <= 1'b0;
      end else if (smp_stb & coll_q) begin
        ws_q <= (ws_q == nshot) ? {SW{1'b0}} : ws_q + 1'b1;
        wp_q <= (ws_q == nshot) ? wp_q + 1'b1 : wp_q;
      end
      // a set arriving while both banks are busy is refused and flagged
      if (coll_end & (!dr_busy_q | dr_end)) begin
        dr_busy_q <= 1'b1;
        rbank_q <= wbank_q;
        wbank_q <= ~wbank_q;
        rs_q <= {{(SW-1){1'b0}}, pair};
        rp_q <= {PW{1'b0}};
      end else if (dr_end) begin
        dr_busy_q <= 1'b0;
      end else if (go & dr_busy_q) begin
        rp_q <= (rp_q == npix) ? {PW{1'b0}} : rp_q + 1'b1;
        if (rp_q == npix) begin
          rs_q <= rs_q + (pair ? 2'd2 : 2'd1);
        end
      end
      // set wins over the clear
      if (coll_end & dr_busy_q & !dr_end) begin
        ovr_q <= 1'b1;
      end else if (wr_do & (AVS_ADDRESS == `ELPC_OFF_STATUS) & AVS_WRITEDATA[`ELPC_STAT_OVR]) begin
        ovr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pair combine: odd shot against the shot before it
  wire signed [15:0] sa;
  wire signed [15:0] sb;
  wire signed [16:0] pdiff;
  wire [6:0] wfar;
  wire signed [23:0] blend;
  reg signed [15:0] x_in;
  assign sa = dmem[{rbank_q, rs_q, rp_q}];
  assign sb = dmem[{rbank_q, rs_q - 1'b1, rp_q}];
  assign pdiff = sb - sa;
  assign wfar = {1'b0, rp_q};
  assign blend = sb * $signed({1'b0, 7'd64 - wfar}) + sa * $signed({1'b0, wfar});
  always @* begin
    x_in = sa;
    if (ctrl_q[`ELPC_CTRL_PINV]) begin
      x_in = pdiff[16:1];
    end else if (ctrl_q[`ELPC_CTRL_FCOMP]) begin
      x_in = blend[21:6];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mixer tables, eight phases, amplitude 127
  function signed [7:0] cosv;
    input [2:0] ph;
    begin
      case (ph)
        3'd0: cosv = 8'sd127;
        3'd1: cosv = 8'sd90;
        3'd2: cosv = 8'sd0;
        3'd3: cosv = -8'sd90;
        3'd4: cosv = -8'sd127;
        3'd5: cosv = -8'sd90;
        3'd6: cosv = 8'sd0;
        default: cosv = 8'sd90;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // demodulation pipeline; every stage holds while the fifo is full
  reg v0, v1, v2, v3, v4, v5, v6, v7, v8;
  reg f0, f1, f2, f3;
  reg [PW-1:0] p0, p1, p2, p3, p4, p5, p6, p7;
  reg signed [15:0] x0;
  reg signed [15:0] dc_q;
  reg signed [16:0] y1;
  reg [15:0] ph_q;
  reg signed [17:0] i2, q2, i3, q3, i4, q4;
  reg signed [17:0] ih [0:2];
  reg signed [17:0] qh [0:2];
  reg [3:0] dcnt_q;
  reg [17:0] mag5;
  reg [15:0] g6;
  reg [7:0] l7, l8, prev_q, pff_q;
  reg [PW-1:0] opix_q;
  reg [(1<<PW)-1:0] fok_q;
  reg [7:0] fmem [0:(1<<PW)-1];
  wire [15:0] inc;
  wire signed [16:0] dcd;
  wire signed [24:0] mi;
  wire signed [24:0] mq;
  wire signed [19:0] si;
  wire signed [19:0] sq;
  wire [17:0] ai;
  wire [17:0] aq;
  wire [8:0] gsum;
  wire [26:0] gp;
  wire [PW+7:0] slope_p;
  wire [8:0] lsum;
  wire [8:0] fsum;
  wire signed [16:0] dc_step;
  wire [7:0] lf;
  wire [7:0] ff;
  wire [9:0] edge_v;
  reg [3:0] msb;
  reg [3:0] mant;
  integer k;
  integer r;
  assign inc = ctrl_q[`ELPC_CTRL_HARM] ? {rxf_q[14:0], 1'b0} : rxf_q;
  assign dcd = x0 - dc_q;
  assign mi = y1 * cosv(ph_q[15:13]);
  assign mq = y1 * cosv(ph_q[15:13] - 3'd2);
  assign si = i2 + ih[0] + ih[1] + ih[2];
  assign sq = q2 + qh[0] + qh[1] + qh[2];
  assign ai = i4[17] ? 18'd0 - i4 : i4;
  assign aq = q4[17] ? 18'd0 - q4 : q4;
  assign slope_p = p5 * gain_q[15:8];
  assign gsum = {1'b0, gain_q[7:0]} + {1'b0, slope_p[13:6]};
  assign gp = mag5 * gsum;
  // line filter restarts at pixel 0; frame filter waits until a pixel has a history
  assign lsum = {1'b0, l8} + {1'b0, prev_q};
  assign lf = (opix_q == {PW{1'b0}}) ? l8 : lsum[8:1];
  assign fsum = {1'b0, lf} + {1'b0, fmem[opix_q]};
  assign ff = fok_q[opix_q] ? fsum[8:1] : lf;
  assign dc_step = dcd >>> `ELPC_DC_SHIFT;
  assign edge_v = {2'b00, ff} + {2'b00, ff} - {2'b00, pff_q};
  // leading one and the four bits under it
  always @* begin
    msb = 4'h0;
    mant = 4'h0;
    for (k = 4; k < 16; k = k + 1) begin
      if (g6[k]) begin
        msb = k[3:0];
        mant = g6[k-1 -: 4];
      end
    end
  end
  always @(posedge CLK) begin
    if (go & v8) begin
      fmem[opix_q] <= ff;
    end
  end
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      {v0, v1, v2, v3, v4, v5, v6, v7, v8} <= 9'h000;
      {f0, f1, f2, f3} <= 4'h0;
      {p0, p1, p2, p3, p4, p5, p6, p7} <= {(8*PW){1'b0}};
      x0 <= 16'h0000;
      dc_q <= 16'h0000;
      y1 <= 17'h0_0000;
      ph_q <= 16'h0000;
      {i2, q2, i3, q3, i4, q4} <= {6{18'h0_0000}};
      for (r = 0; r < 3; r = r + 1) begin
        ih[r] <= 18'h0_0000;
        qh[r] <= 18'h0_0000;
      end
      dcnt_q <= 4'h0;
      mag5 <= 18'h0_0000;
      g6 <= 16'h0000;
      {l7, l8, prev_q, pff_q} <= 32'h0000_0000;
      opix_q <= {PW{1'b0}};
      fok_q <= {(1<<PW){1'b0}};
    end else if (go) begin
      v0 <= dr_busy_q;
      x0 <= x_in;
      p0 <= rp_q;
      f0 <= (rp_q == {PW{1'b0}});
      v1 <= v0;
      f1 <= f0;
      p1 <= p0;
      y1 <= dcd;
      if (v0) begin
        dc_q <= dc_q + dc_step[15:0];
      end
      v2 <= v1;
      f2 <= f1;
      p2 <= p1;
      i2 <= mi[24:7];
      q2 <= mq[24:7];
      if (v1) begin
        ph_q <= f1 ? inc : ph_q + inc;
      end
      v3 <= v2;
      f3 <= f2;
      p3 <= p2;
      i3 <= si[19:2];
      q3 <= sq[19:2];
      if (v2) begin
        ih[0] <= i2;
        ih[1] <= ih[0];
        ih[2] <= ih[1];
        qh[0] <= q2;
        qh[1] <= qh[0];
        qh[2] <= qh[1];
      end
      // keep one of every n filtered samples
      v4 <= v3 & (f3 | dcnt_q == 4'h0);
      if (v3) begin
        dcnt_q <= (f3 | dcnt_q == 4'h0) ? shape_q[11:8] : dcnt_q - 4'h1;
        if (f3) begin
          dcnt_q <= shape_q[11:8];
        end
      end
      p4 <= p3;
      i4 <= i3;
      q4 <= q3;
      v5 <= v4;
      p5 <= p4;
      mag5 <= (ai > aq) ? ai + (aq >> 1) : aq + (ai >> 1);
      v6 <= v5;
      g6 <= (|gp[26:24]) ? 16'hFFFF : gp[23:8];
      v7 <= v6;
      l7 <= (g6 == 16'h0000) ? 8'h00 : {msb, mant};
      v8 <= v7;
      l8 <= l7;
      p6 <= p5;
      p7 <= p6;
      opix_q <= p7; // pixel index of the word in the last stage
      if (v8) begin
        prev_q <= l8;
        pff_q <= ff;
        fok_q[opix_q] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output select and fifo; doppler taps the baseband before magnitude
  wire f_valid;
  wire [32:0] f_data;
  wire f_out_ready;
  wire o_v;
  wire [31:0] o_w;
  wire resmp_skip;
  assign go = f_in_ready;
  assign resmp_skip = ctrl_q[`ELPC_CTRL_RESMP] & opix_q[0];
  assign o_v = dop ? v4 : (v8 & ~resmp_skip);
  assign o_w = dop ? {i4[17:2], q4[17:2]} : {24'h00_0000, (|edge_v[9:8]) ? 8'hFF : edge_v[7:0]};
  assign f_out_ready = ~SD_WR_VALID | SD_WR_READY;
  elpc_fifo #(
    .W(33),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .rst(RESET),
    .in_data({(mode == `ELPC_MODE_M) | dop, o_w}),
    .in_valid(o_v),
    .in_ready(f_in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_out_ready)
  );
  // registered port stage, drained only when the SDRAM side accepts
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SD_WR_VALID <= 1'b0;
      SD_WR_DATA <= 32'h0000_0000;
      SD_DMA_SEL <= 1'b0;
      SD_CHAN <= 2'h0;
    end else if (f_out_ready) begin
      SD_WR_VALID <= f_valid;
      SD_WR_DATA <= f_data[31:0];
      SD_DMA_SEL <= f_data[32];
      SD_CHAN <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// ==== include/elpc_map.vh ====
// constants of the echo line processing chain
// assumes: included by bare name from core files
// Function
// - drive beamformer clock enable (200 MHz) and per-shot trigger
// - load transmit, focus, line, apodization, multibeam before each shot
// - reorder pixel-major multibeam samples into shot-major lines
// - cancel DC, mix to baseband, then low-pass filter
// - decimate to pixel rate and take complex magnitude
// - depth gain then log compress to 8 bits
// - line filter, frame filter, resample, edge enhance
// - harmonic option doubles the receive mixing frequency
// - pulse inversion subtracts two opposite shots sample by sample
// - focus composite blends near and far focus shots into one line
// - brightness data goes via channel zero, DMA 0
// - motion-line data goes via channel zero, DMA 1
// - Doppler demodulated data goes via channel zero, DMA 1
// - compound and slice contrast use the plain brightness path
`ifndef ELPC_MAP_VH
`define ELPC_MAP_VH
// byte offsets
`define ELPC_OFF_CTRL 6'h00
`define ELPC_OFF_STATUS 6'h04
`define ELPC_OFF_PRF 6'h08
`define ELPC_OFF_TXSET 6'h0C
`define ELPC_OFF_LINE 6'h10
`define ELPC_OFF_RXF 6'h14
`define ELPC_OFF_GAIN 6'h18
`define ELPC_OFF_SHAPE 6'h1C
// control fields
`define ELPC_CTRL_EN 0
`define ELPC_CTRL_MODE 2:1
`define ELPC_CTRL_HARM 3
`define ELPC_CTRL_PINV 4
`define ELPC_CTRL_FCOMP 5
`define ELPC_CTRL_RESMP 6
`define ELPC_STAT_OVR 1
// modes
`define ELPC_MODE_B 2'h0
`define ELPC_MODE_M 2'h1
`define ELPC_MODE_D 2'h2
// reset values
`define ELPC_RST_PRF 24'h00_1388
`define ELPC_RST_TXSET 32'h0000_0004
`define ELPC_RST_RXF 16'h2000
`define ELPC_RST_GAIN 16'h0040
`define ELPC_RST_SHAPE 12'h03F
// timing
`define ELPC_BF_CLK_MHZ 200
`define ELPC_CFG_WORDS 2'h3
`define ELPC_DC_SHIFT 6
`endif

// ==== test/elpc_bf_model.sv ====
// beamformer stand-in: answers each shot trigger with one frame of samples
// assumes: trigger in the core clock domain; link clock 125 ns, only in frames
`timescale 1ns/1ps
`default_nettype none
module elpc_bf_model (
  input wire logic clk, // core clock
  input wire logic trig, // shot trigger
  input wire logic [2:0] nshot, // parallel shots
  input wire logic [6:0] npix, // pixels per shot
  input wire logic pinv, // odd shots inverted
  input wire logic slow, // late first sample
  output logic smp_clk, // link clock
  output logic [15:0] smp_data // sample
);
  logic [15:0] v;
  initial begin
    smp_clk = 1'b0;
    smp_data = 16'h0000;
  end
  ////////////////////////////////////////
  // pixel-major across shots; data set on the falling edge so it holds past the rise
  always begin
    @(posedge clk iff trig === 1'b1);
    #(slow ? 500 : 10);
    for (int p = 0; p < npix; p++) begin
      for (int s = 0; s < nshot; s++) begin
        v = 16'h0100 + 16'(p * 64) + 16'(s * 16);
        smp_data = (pinv && s[0]) ? -v : v;
        #62.5 smp_clk = 1'b1;
        #62.5 smp_clk = 1'b0;
      end
    end
    smp_data = ~smp_data; // a released line must not show the last value
  end
endmodule
`default_nettype wire

// ==== test/elpc_chk_sva.sv ====
// checker: bus, shot and stream timing at the chain's top ports
// assumes: bound to elpc_top, one clock domain, async reset
`timescale 1ns/1ps
`default_nettype none
module elpc_chk (
  input wire CLK, // core clock
  input wire RESET, // async reset
  input wire [5:0] AVS_ADDRESS, // byte address
  input wire AVS_READ, // read request
  input wire AVS_WRITE, // write request
  input wire [31:0] AVS_READDATA, // read data
  input wire AVS_WAITREQUEST, // stall
  input wire BF_CLK_EN, // clock enable
  input wire SHOT_TRIG, // shot start
  input wire CFG_STB, // config strobe
  input wire [1:0] CFG_ADDR, // config index
  input wire [31:0] SD_WR_DATA, // stream word
  input wire SD_WR_VALID, // stream valid
  input wire SD_WR_READY, // stream ready
  input wire SD_DMA_SEL, // dma index
  input wire [1:0] SD_CHAN // channel
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////
  // a shot is three indexed config words, then a single trigger
  sequence cfg_words;
    CFG_STB && CFG_ADDR == 2'h0 ##1 CFG_STB && CFG_ADDR == 2'h1 ##1 CFG_STB && CFG_ADDR == 2'h2;
  endsequence
  sequence fire;
    !CFG_STB && SHOT_TRIG ##1 !SHOT_TRIG;
  endsequence
  chk_cfg_then_trig: assert property ($rose(CFG_STB) |-> cfg_words ##1 fire)
    else $error("config burst malformed");
  chk_trig_source: assert property (SHOT_TRIG |-> $past(CFG_STB) && $past(CFG_ADDR) == 2'h2)
    else $error("trigger without config");
  chk_burst_enabled: assert property ($rose(CFG_STB) |-> BF_CLK_EN)
    else $error("shot while disabled");
  chk_idle_quiet: assert property (!BF_CLK_EN [*3] |-> !$rose(CFG_STB))
    else $error("shot after disable");
  ////////////////////////////////////////
  // register bus answers after exactly one wait state
  chk_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  chk_bus_release: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("bus wait not restored");
  chk_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[5] |-> AVS_READDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  ////////////////////////////////////////
  // stream towards the sdram fifo never drops or alters a stalled word
  chk_stream_hold: assert property (SD_WR_VALID && !SD_WR_READY |=> SD_WR_VALID && $stable(SD_WR_DATA) && $stable(SD_DMA_SEL))
    else $error("stalled word changed");
  chk_chan_zero: assert property (SD_WR_VALID |-> SD_CHAN == 2'h0)
    else $error("channel not zero");
endmodule
bind elpc_top elpc_chk u_chk (.CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .BF_CLK_EN(BF_CLK_EN),
  .SHOT_TRIG(SHOT_TRIG), .CFG_STB(CFG_STB), .CFG_ADDR(CFG_ADDR), .SD_WR_DATA(SD_WR_DATA), .SD_WR_VALID(SD_WR_VALID),
  .SD_WR_READY(SD_WR_READY), .SD_DMA_SEL(SD_DMA_SEL), .SD_CHAN(SD_CHAN));
`default_nettype wire

// ==== test/elpc_tb_top.sv ====
// bench: register bus, beamformer model and a stalling sink around the chain
// assumes: design, header, checker and beamformer model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "elpc_map.vh"
module elpc_tb_top;
  localparam int NSHOT = 2;
  localparam int NPIX = 8;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [5:0] AVS_ADDRESS = 6'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic SD_WR_READY = 1'b0;
  logic [31:0] AVS_READDATA, CFG_DATA, SD_WR_DATA;
  logic AVS_WAITREQUEST, BF_CLK_EN, SHOT_TRIG, CFG_STB, SD_WR_VALID, SD_DMA_SEL, SMP_CLK;
  logic [1:0] CFG_ADDR, SD_CHAN;
  logic [15:0] SMP_DATA;
  logic [15:0] rnd_q = 16'h0058;
  logic [6:0] ctrl = 7'h00;
  logic [31:0] cfg_q [0:2];
  logic [6:0] modes [0:7] = '{7'h01, 7'h03, 7'h05, 7'h07, 7'h09, 7'h11, 7'h21, 7'h41};
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int hold_until = 0;
  int trig_cnt = 0;
  int w_cnt = 0;
  always #4 CLK = ~CLK;
  elpc_top #(.PW(6), .SW(2), .FIFO_DEPTH(8), .FIFO_AW(3)) uut (.CLK(CLK), .RESET(RESET),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .BF_CLK_EN(BF_CLK_EN), .SHOT_TRIG(SHOT_TRIG),
    .CFG_STB(CFG_STB), .CFG_ADDR(CFG_ADDR), .CFG_DATA(CFG_DATA), .SMP_CLK(SMP_CLK), .SMP_DATA(SMP_DATA),
    .SD_WR_DATA(SD_WR_DATA), .SD_WR_VALID(SD_WR_VALID), .SD_WR_READY(SD_WR_READY), .SD_DMA_SEL(SD_DMA_SEL),
    .SD_CHAN(SD_CHAN));
  elpc_bf_model bfm (.clk(CLK), .trig(SHOT_TRIG), .nshot(3'(NSHOT)), .npix(7'(NPIX)), .pinv(ctrl[4]),
    .slow(ctrl[1]), .smp_clk(SMP_CLK), .smp_data(SMP_DATA));
  ////////////////////////////////////////
  function automatic [15:0] lfsr_next(input [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // pair modes keep one line per two shots, resampling keeps every other pixel
  function automatic int exp_words(input [6:0] c);
    exp_words = NPIX * NSHOT / ((c[4] || c[5]) ? 2 : 1) / (c[6] ? 2 : 1);
  endfunction
  function automatic logic exp_dma(input [6:0] c);
    exp_dma = (c[2:1] == 2'h1) || (c[2:1] == 2'h2);
  endfunction
  task automatic check(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bail;
    err_count++;
    give_verdict();
  endtask
  // one bus access: hold everything until waitrequest is sampled low
  task automatic av_go(input logic wr, input [5:0] a, input [31:0] d, output [31:0] q);
    int i;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (AVS_WAITREQUEST !== 1'b0 && i < 64);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (i >= 64) bail();
  endtask
  task automatic av_wr(input [5:0] a, input [31:0] d);
    logic [31:0] q;
    av_go(1'b1, a, d, q);
  endtask
  task automatic av_rd(input [5:0] a, input [31:0] exp);
    logic [31:0] q;
    av_go(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask
  task automatic wait_trig(input int n);
    int i;
    i = 0;
    while (trig_cnt < n && i < 5000) begin
      @(posedge CLK);
      i++;
    end
    if (i >= 5000) bail();
  endtask
  ////////////////////////////////////////
  // sink with random stalls, forced off for a while to fill the fifo
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    rnd_q <= lfsr_next(rnd_q);
    SD_WR_READY <= (cyc < hold_until) ? 1'b0 : (rnd_q[0] | rnd_q[3]);
    if (SHOT_TRIG === 1'b1) trig_cnt <= trig_cnt + 1;
    if (CFG_STB === 1'b1) cfg_q[CFG_ADDR] <= CFG_DATA;
    if (SD_WR_VALID === 1'b1 && SD_WR_READY === 1'b1) begin
      w_cnt <= w_cnt + 1;
      check({31'h0, SD_DMA_SEL}, {31'h0, exp_dma(ctrl)});
      if (ctrl[2:1] != 2'h2) check({8'h00, SD_WR_DATA[31:8]}, 32'h0000_0000);
    end
  end
  ////////////////////////////////////////
  initial begin
    logic [31:0] txset, line, prf, q;
    int bt, bw, t0, n, i;
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    av_rd(`ELPC_OFF_CTRL, 32'h0000_0000);
    av_rd(`ELPC_OFF_PRF, {8'h00, `ELPC_RST_PRF});
    av_rd(`ELPC_OFF_TXSET, `ELPC_RST_TXSET);
    av_rd(`ELPC_OFF_RXF, {16'h0000, `ELPC_RST_RXF});
    av_rd(`ELPC_OFF_GAIN, {16'h0000, `ELPC_RST_GAIN});
    av_rd(`ELPC_OFF_SHAPE, {20'h0_0000, `ELPC_RST_SHAPE});
    av_wr(6'h20, 32'hFFFF_FFFF);
    av_rd(6'h20, 32'h0000_0000);
    av_wr(`ELPC_OFF_SHAPE, 32'(NPIX - 1));
    prf = 32'h0000_0258 + {24'h00_0000, rnd_q[7:0]};
    av_wr(`ELPC_OFF_PRF, prf);
    foreach (modes[m]) begin
      txset = {16'h0000, rnd_q | 16'h0002}; // divide ratio in the low bits stays two or more
      line = {6'h00, 2'(NSHOT - 1), 8'h00, rnd_q ^ 16'h5A5A};
      av_wr(`ELPC_OFF_TXSET, txset);
      av_wr(`ELPC_OFF_LINE, line);
      bt = trig_cnt;
      bw = w_cnt;
      ctrl = modes[m];
      av_wr(`ELPC_OFF_CTRL, {25'h000_0000, ctrl});
      wait_trig(bt + 1);
      t0 = cyc;
      if (m == 0) hold_until = cyc + 400; // stall the sink over the first frame so the fifo fills
      check(cfg_q[0], txset);
      check(cfg_q[1], line);
      check({26'h000_0000, cfg_q[2][5:0]}, {26'h000_0000, ctrl[5:0]});
      if (m == 0) begin
        wait_trig(bt + 2);
        check(32'(cyc - t0), prf + 32'h0000_0005);
      end
      av_wr(`ELPC_OFF_CTRL, {25'h000_0000, ctrl & 7'h7E});
      n = (trig_cnt - bt) * exp_words(ctrl);
      i = 0;
      while (w_cnt - bw < n && i < 20000) begin
        @(posedge CLK);
        i++;
      end
      if (i >= 20000) bail();
      repeat (200) @(posedge CLK);
      check(32'(w_cnt - bw), 32'(n));
    end
    av_go(1'b0, `ELPC_OFF_STATUS, 32'h0000_0000, q);
    check({28'h000_0000, q[3:0]}, 32'h0000_0000);
    give_verdict();
  end
endmodule
`default_nettype wire
